// [common/bsac_pkg.sv]
// Constants and types for the AC-coupled boundary-scan block
package bsac_pkg;
  localparam int IR_W = 10;
  localparam int ID_W = 32;
  localparam int N_IO = 8;
  localparam int N_LANE = 8;
  localparam int N_REFCLK = 8;
  localparam int N_AC = N_LANE + N_REFCLK;
  localparam int N_EXT = N_IO + N_AC;
  localparam int N_CFG = 3;

  // Instruction opcodes
  localparam logic [9:0] OP_EXTEST_PULSE = 10'h08F;
  localparam logic [9:0] OP_EXTEST_TRAIN = 10'h04F;
  localparam logic [9:0] OP_EXTEST = 10'h00F;
  localparam logic [9:0] OP_SAMPLE = 10'h005;
  localparam logic [9:0] OP_DEVICE_IDENTIFICATION = 10'h006;
  localparam logic [9:0] OP_BYPASS = 10'h3FF;
  localparam logic [9:0] IR_CAPTURE = 10'h001;

  // Boundary chain length per device size
  localparam int BSR_LEN_SMALL = 1227;
  localparam int BSR_LEN_MID = 1467;
  localparam int BSR_LEN_LARGE = 1971;

  // Identification fields, MSB first
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  localparam int ID_FIXED_BIT = 0;
  // Arbitrary identity values
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [10:0] ID_MFR = 11'h2A5;
  localparam logic [15:0] ID_PART_SMALL = 16'hA101;
  localparam logic [15:0] ID_PART_MID = 16'hA102;
  localparam logic [15:0] ID_PART_LARGE = 16'hA103;
  localparam logic [31:0] ID_INVALID = 32'h0000_0001;

  // Boundary cell map
  localparam int CELL_IO_BASE = 0;
  localparam int CELL_IO_STRIDE = 3;
  localparam int CELL_TX_BASE = CELL_IO_BASE + CELL_IO_STRIDE * N_IO;
  localparam int CELL_AC_BASE = CELL_TX_BASE + N_LANE;
  localparam int CELL_END = CELL_AC_BASE + N_AC;

  // Configuration pin positions in the sync vector
  localparam int CFG_START = 0;
  localparam int CFG_STATUS = 1;
  localparam int CFG_DONE = 2;

  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008, TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020,
    TAP_PA_DR = 16'h0040, TAP_EX2_DR = 16'h0080, TAP_UP_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PA_IR = 16'h2000, TAP_EX2_IR = 16'h4000,
    TAP_UP_IR = 16'h8000
  } bsac_tap_t;

  typedef enum logic [5:0] {
    INS_BYPASS = 6'h01, INS_DEVICE_IDENTIFICATION = 6'h02, INS_SAMPLE = 6'h04,
    INS_EXTEST = 6'h08, INS_PULSE = 6'h10, INS_TRAIN = 6'h20
  } bsac_ins_t;

  function automatic int bsr_len(input logic [1:0] size);
    return (size == 2'h0) ? BSR_LEN_SMALL : (size == 2'h1) ? BSR_LEN_MID : BSR_LEN_LARGE;
  endfunction : bsr_len

  function automatic logic [15:0] id_part(input logic [1:0] size);
    return (size == 2'h0) ? ID_PART_SMALL : (size == 2'h1) ? ID_PART_MID : ID_PART_LARGE;
  endfunction : id_part
endpackage : bsac_pkg

// [core/bsac_tx_pulse.sv]
// Falling-edge transmitter driver for pulse and train tests
`timescale 1ns/1ps
`default_nettype none
module bsac_tx_pulse (
  input wire logic tck,
  input wire logic clr,
  input wire logic drive,
  input wire logic train,
  input wire logic edge_mode,
  input wire logic in_update,
  input wire logic in_rti,
  input wire logic [bsac_pkg::N_LANE-1:0] data,
  output logic [2*bsac_pkg::N_LANE-1:0] tx_pair
);
  logic [bsac_pkg::N_LANE-1:0] tx_reg;
  logic was_rti_reg;

  always_ff @(negedge tck)
  begin
    if (clr)
    begin
      was_rti_reg <= 1'b0;
    end
    else
    begin
      was_rti_reg <= in_rti;
    end
  end

  always_ff @(negedge tck)
  begin
    if (clr || !drive)
    begin
      tx_reg <= '0;
    end
    else if (in_update)
    begin
      tx_reg <= data;
    end
    else if (edge_mode && in_rti && !was_rti_reg)
    begin
      tx_reg <= ~data;
    end
    else if (edge_mode && train && in_rti)
    begin
      tx_reg <= ~tx_reg;
    end
    else if (!in_rti && was_rti_reg)
    begin
      tx_reg <= data;
    end
  end

  // Differential pair, positive leg even
  for (genvar i = 0; i < bsac_pkg::N_LANE; i++)
  begin : g_pair
    assign tx_pair[2*i] = tx_reg[i];
    assign tx_pair[2*i+1] = ~tx_reg[i];
  end
endmodule : bsac_tx_pulse
`default_nettype wire

// [core/bsac_top.sv]
// Boundary-scan test port with AC-coupled pulse and train tests
`timescale 1ns/1ps
`default_nettype none
module bsac_top #(
  parameter logic [1:0] DEV_SIZE = 2'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic config_start_n,
  input wire logic config_status_n,
  input wire logic config_done,
  output logic scan_test_mode,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [bsac_pkg::N_IO-1:0] io_in,
  output logic [bsac_pkg::N_IO-1:0] io_out,
  output logic [bsac_pkg::N_IO-1:0] io_oe,
  output logic [2*bsac_pkg::N_LANE-1:0] serial_tx_pair,
  input wire logic [bsac_pkg::N_LANE-1:0] serial_rx_pair,
  input wire logic [bsac_pkg::N_REFCLK-1:0] ref_clock_inputs
);
  localparam int BSR_LEN = bsac_pkg::bsr_len(DEV_SIZE);
  localparam int N_EXT = bsac_pkg::N_EXT;
  localparam int N_AC = bsac_pkg::N_AC;

  // Clock domain: configuration pins
  logic [bsac_pkg::N_CFG-1:0] cfg_s1;
  logic [bsac_pkg::N_CFG-1:0] cfg_s2;
  logic [bsac_pkg::N_CFG-1:0] cfg_s3;
  logic [bsac_pkg::N_CFG-1:0] cfg_lvl_reg;
  logic [bsac_pkg::N_CFG-1:0] cfg_agree;
  logic [1:0] cfg_state_reg;
  logic mode_s1;

  // Test clock domain
  logic rst_s1;
  logic rst_s2;
  logic rst_s3;
  logic tck_rst_n_reg;
  logic tap_clr;
  logic [1:0] cfg_x1;
  logic [1:0] cfg_x2;
  logic id_ok_t;
  logic cfg_done_t;
  bsac_pkg::bsac_tap_t state_reg;
  bsac_pkg::bsac_tap_t state_next;
  bsac_pkg::bsac_ins_t ins_reg;
  bsac_pkg::bsac_ins_t ins_next;
  logic [bsac_pkg::IR_W-1:0] ir_shift_reg;
  logic [bsac_pkg::ID_W-1:0] id_shift_reg;
  logic [bsac_pkg::ID_W-1:0] id_value;
  logic bypass_reg;
  logic [BSR_LEN-1:0] bsr_shift_reg;
  logic [BSR_LEN-1:0] bsr_upd_reg;
  logic [BSR_LEN-1:0] bsr_upd_next;
  logic [BSR_LEN-1:0] bsr_cap;
  logic [N_EXT-1:0] ext_in;
  logic [N_EXT-1:0] ext_s1;
  logic [N_EXT-1:0] ext_s2;
  logic [N_EXT-1:0] ext_s3;
  logic [N_EXT-1:0] ext_lvl_reg;
  logic [N_EXT-1:0] ext_agree;
  logic [N_EXT-1:0] ext_chg;
  logic [N_AC-1:0] ac_seen_reg;
  logic [N_AC-1:0] ac_seen_next;
  logic bsr_sel;
  logic drive_next;
  logic edge_next;
  logic test_active_reg;
  logic tdo_reg;
  logic tdo_oe_reg;
  logic [bsac_pkg::N_IO-1:0] io_out_reg;
  logic [bsac_pkg::N_IO-1:0] io_oe_reg;
  logic [bsac_pkg::N_LANE-1:0] tx_data;

  function automatic bsac_pkg::bsac_tap_t tap_step(input bsac_pkg::bsac_tap_t s,
                                                   input logic m);
    unique case (s)
      bsac_pkg::TAP_TLR: return m ? bsac_pkg::TAP_TLR : bsac_pkg::TAP_RTI;
      bsac_pkg::TAP_RTI: return m ? bsac_pkg::TAP_SEL_DR : bsac_pkg::TAP_RTI;
      bsac_pkg::TAP_SEL_DR: return m ? bsac_pkg::TAP_SEL_IR : bsac_pkg::TAP_CAP_DR;
      bsac_pkg::TAP_CAP_DR: return m ? bsac_pkg::TAP_EX1_DR : bsac_pkg::TAP_SH_DR;
      bsac_pkg::TAP_SH_DR: return m ? bsac_pkg::TAP_EX1_DR : bsac_pkg::TAP_SH_DR;
      bsac_pkg::TAP_EX1_DR: return m ? bsac_pkg::TAP_UP_DR : bsac_pkg::TAP_PA_DR;
      bsac_pkg::TAP_PA_DR: return m ? bsac_pkg::TAP_EX2_DR : bsac_pkg::TAP_PA_DR;
      bsac_pkg::TAP_EX2_DR: return m ? bsac_pkg::TAP_UP_DR : bsac_pkg::TAP_SH_DR;
      bsac_pkg::TAP_UP_DR: return m ? bsac_pkg::TAP_SEL_DR : bsac_pkg::TAP_RTI;
      bsac_pkg::TAP_SEL_IR: return m ? bsac_pkg::TAP_TLR : bsac_pkg::TAP_CAP_IR;
      bsac_pkg::TAP_CAP_IR: return m ? bsac_pkg::TAP_EX1_IR : bsac_pkg::TAP_SH_IR;
      bsac_pkg::TAP_SH_IR: return m ? bsac_pkg::TAP_EX1_IR : bsac_pkg::TAP_SH_IR;
      bsac_pkg::TAP_EX1_IR: return m ? bsac_pkg::TAP_UP_IR : bsac_pkg::TAP_PA_IR;
      bsac_pkg::TAP_PA_IR: return m ? bsac_pkg::TAP_EX2_IR : bsac_pkg::TAP_PA_IR;
      bsac_pkg::TAP_EX2_IR: return m ? bsac_pkg::TAP_UP_IR : bsac_pkg::TAP_SH_IR;
      bsac_pkg::TAP_UP_IR: return m ? bsac_pkg::TAP_SEL_DR : bsac_pkg::TAP_RTI;
      default: return bsac_pkg::TAP_TLR;
    endcase
  endfunction : tap_step

  function automatic bsac_pkg::bsac_ins_t op_decode(input logic [9:0] op,
                                                    input logic done);
    unique case (op)
      bsac_pkg::OP_DEVICE_IDENTIFICATION: return bsac_pkg::INS_DEVICE_IDENTIFICATION;
      bsac_pkg::OP_SAMPLE: return bsac_pkg::INS_SAMPLE;
      bsac_pkg::OP_EXTEST: return bsac_pkg::INS_EXTEST;
      bsac_pkg::OP_EXTEST_PULSE: return done ? bsac_pkg::INS_PULSE : bsac_pkg::INS_BYPASS;
      bsac_pkg::OP_EXTEST_TRAIN: return done ? bsac_pkg::INS_TRAIN : bsac_pkg::INS_BYPASS;
      default: return bsac_pkg::INS_BYPASS;
    endcase
  endfunction : op_decode

  // Configuration pins, three-stage sync
  always_ff @(posedge clk)
  begin
    cfg_s1 <= {config_done, config_status_n, config_start_n};
    cfg_s2 <= cfg_s1;
    cfg_s3 <= cfg_s2;
  end

  assign cfg_agree = ~(cfg_s2 ^ cfg_s3);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_lvl_reg <= '0;
      cfg_state_reg <= 2'h0;
    end
    else
    begin
      cfg_lvl_reg <= (cfg_lvl_reg & ~cfg_agree) | (cfg_s3 & cfg_agree);
      // identity valid only out of reset
      cfg_state_reg[0] <= cfg_lvl_reg[bsac_pkg::CFG_START] &
                          cfg_lvl_reg[bsac_pkg::CFG_STATUS];
      cfg_state_reg[1] <= cfg_lvl_reg[bsac_pkg::CFG_DONE];
    end
  end

  // Test activity back into clock domain
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_s1 <= 1'b0;
      scan_test_mode <= 1'b0;
    end
    else
    begin
      mode_s1 <= test_active_reg;
      scan_test_mode <= mode_s1;
    end
  end

  // Reset into test clock domain
  always_ff @(posedge tck)
  begin
    rst_s1 <= rst_n;
    rst_s2 <= rst_s1;
    rst_s3 <= rst_s2;
    if (rst_s2 == rst_s3)
    begin
      tck_rst_n_reg <= rst_s3;
    end
  end

  // no test reset pin; state walk or synced rst_n
  assign tap_clr = !tck_rst_n_reg || (state_reg == bsac_pkg::TAP_TLR);

  // Configuration levels into test clock domain
  always_ff @(posedge tck)
  begin
    cfg_x1 <= cfg_state_reg;
    cfg_x2 <= cfg_x1;
  end

  assign id_ok_t = cfg_x2[0];
  assign cfg_done_t = cfg_x2[1];

  // TAP controller
  assign state_next = tap_step(state_reg, tms);

  always_ff @(posedge tck)
  begin
    if (!tck_rst_n_reg)
    begin
      state_reg <= bsac_pkg::TAP_TLR;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Instruction register
  always_ff @(posedge tck)
  begin
    if (tap_clr)
    begin
      ir_shift_reg <= bsac_pkg::IR_CAPTURE;
    end
    else if (state_reg == bsac_pkg::TAP_CAP_IR)
    begin
      ir_shift_reg <= bsac_pkg::IR_CAPTURE;
    end
    else if (state_reg == bsac_pkg::TAP_SH_IR)
    begin
      ir_shift_reg <= {tdi, ir_shift_reg[bsac_pkg::IR_W-1:1]};
    end
  end

  assign ins_next = (state_reg == bsac_pkg::TAP_UP_IR) ?
                    op_decode(ir_shift_reg, cfg_done_t) : ins_reg;

  always_ff @(negedge tck)
  begin
    if (tap_clr)
    begin
      ins_reg <= bsac_pkg::INS_DEVICE_IDENTIFICATION;
    end
    else
    begin
      ins_reg <= ins_next;
    end
  end

  assign drive_next = (ins_next == bsac_pkg::INS_EXTEST) ||
                      (ins_next == bsac_pkg::INS_PULSE) ||
                      (ins_next == bsac_pkg::INS_TRAIN);
  assign edge_next = (ins_next == bsac_pkg::INS_PULSE) ||
                     (ins_next == bsac_pkg::INS_TRAIN);
  assign bsr_sel = (ins_reg != bsac_pkg::INS_DEVICE_IDENTIFICATION) &&
                   (ins_reg != bsac_pkg::INS_BYPASS);

  assign id_value = id_ok_t ?
    {bsac_pkg::ID_VERSION, bsac_pkg::id_part(DEV_SIZE), bsac_pkg::ID_MFR, 1'b1} :
    bsac_pkg::ID_INVALID;

  // Pin inputs, three-stage sync
  assign ext_in = {ref_clock_inputs, serial_rx_pair, io_in};

  always_ff @(posedge tck)
  begin
    ext_s1 <= ext_in;
    ext_s2 <= ext_s1;
    ext_s3 <= ext_s2;
  end

  assign ext_agree = ~(ext_s2 ^ ext_s3);
  assign ext_chg = ext_agree & (ext_s3 ^ ext_lvl_reg);

  always_ff @(posedge tck)
  begin
    if (!tck_rst_n_reg)
    begin
      ext_lvl_reg <= '0;
    end
    else
    begin
      ext_lvl_reg <= (ext_lvl_reg & ~ext_agree) | (ext_s3 & ext_agree);
    end
  end

  always_comb
  begin
    ac_seen_next = ac_seen_reg;
    if (state_reg == bsac_pkg::TAP_UP_DR)
    begin
      ac_seen_next = '0;
    end
    if ((ins_reg == bsac_pkg::INS_PULSE) || (ins_reg == bsac_pkg::INS_TRAIN))
    begin
      ac_seen_next = ac_seen_next | ext_chg[N_EXT-1:bsac_pkg::N_IO];
    end
  end

  always_ff @(posedge tck)
  begin
    if (tap_clr)
    begin
      ac_seen_reg <= '0;
    end
    else
    begin
      ac_seen_reg <= ac_seen_next;
    end
  end

  // Capture values per cell
  // lane cells distinct
  for (genvar i = 0; i < BSR_LEN; i++)
  begin : g_cap
    if (i < bsac_pkg::CELL_TX_BASE)
    begin : g_io
      if ((i % bsac_pkg::CELL_IO_STRIDE) == 0)
      begin : g_in
        assign bsr_cap[i] = ext_lvl_reg[i / bsac_pkg::CELL_IO_STRIDE];
      end
      else
      begin : g_ctl
        assign bsr_cap[i] = bsr_upd_reg[i];
      end
    end
    else if (i < bsac_pkg::CELL_AC_BASE)
    begin : g_tx
      assign bsr_cap[i] = serial_tx_pair[2*(i-bsac_pkg::CELL_TX_BASE)];
    end
    else if (i < bsac_pkg::CELL_END)
    begin : g_ac
      assign bsr_cap[i] = ((ins_reg == bsac_pkg::INS_PULSE) ||
                           (ins_reg == bsac_pkg::INS_TRAIN)) ?
                          ac_seen_reg[i-bsac_pkg::CELL_AC_BASE] :
                          ext_lvl_reg[bsac_pkg::N_IO + i - bsac_pkg::CELL_AC_BASE];
    end
    else
    begin : g_int
      assign bsr_cap[i] = bsr_upd_reg[i];
    end
  end

  // Data registers
  always_ff @(posedge tck)
  begin
    if (tap_clr)
    begin
      id_shift_reg <= '0;
      bypass_reg <= 1'b0;
    end
    else if (state_reg == bsac_pkg::TAP_CAP_DR)
    begin
      id_shift_reg <= id_value;
      bypass_reg <= 1'b0;
    end
    else if (state_reg == bsac_pkg::TAP_SH_DR)
    begin
      id_shift_reg <= {tdi, id_shift_reg[bsac_pkg::ID_W-1:1]};
      bypass_reg <= tdi;
    end
  end

  always_ff @(posedge tck)
  begin
    if (!tck_rst_n_reg)
    begin
      bsr_shift_reg <= '0;
    end
    else if ((state_reg == bsac_pkg::TAP_CAP_DR) && bsr_sel)
    begin
      bsr_shift_reg <= bsr_cap;
    end
    else if ((state_reg == bsac_pkg::TAP_SH_DR) && bsr_sel)
    begin
      bsr_shift_reg <= {tdi, bsr_shift_reg[BSR_LEN-1:1]};
    end
  end

  assign bsr_upd_next = ((state_reg == bsac_pkg::TAP_UP_DR) && bsr_sel) ?
                        bsr_shift_reg : bsr_upd_reg;

  always_ff @(negedge tck)
  begin
    if (!tck_rst_n_reg)
    begin
      bsr_upd_reg <= '0;
    end
    else
    begin
      bsr_upd_reg <= bsr_upd_next;
    end
  end

  // General pin drive on falling edge
  for (genvar k = 0; k < bsac_pkg::N_IO; k++)
  begin : g_io_drv
    always_ff @(negedge tck)
    begin
      if (tap_clr || !drive_next)
      begin
        io_out_reg[k] <= 1'b0;
        io_oe_reg[k] <= 1'b0;
      end
      else
      begin
        io_out_reg[k] <= bsr_upd_next[bsac_pkg::CELL_IO_STRIDE*k+1];
        io_oe_reg[k] <= bsr_upd_next[bsac_pkg::CELL_IO_STRIDE*k+2];
      end
    end
  end

  assign io_out = io_out_reg;
  assign io_oe = io_oe_reg;

  always_ff @(negedge tck)
  begin
    if (tap_clr)
    begin
      test_active_reg <= 1'b0;
    end
    else
    begin
      test_active_reg <= drive_next;
    end
  end

  // Test data out on falling edge
  always_ff @(negedge tck)
  begin
    if (!tck_rst_n_reg)
    begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end
    else
    begin
      tdo_oe_reg <= (state_reg == bsac_pkg::TAP_SH_IR) ||
                    (state_reg == bsac_pkg::TAP_SH_DR);
      if (state_reg == bsac_pkg::TAP_SH_IR)
      begin
        tdo_reg <= ir_shift_reg[0];
      end
      else if (ins_reg == bsac_pkg::INS_DEVICE_IDENTIFICATION)
      begin
        tdo_reg <= id_shift_reg[0];
      end
      else if (ins_reg == bsac_pkg::INS_BYPASS)
      begin
        tdo_reg <= bypass_reg;
      end
      else
      begin
        tdo_reg <= bsr_shift_reg[0];
      end
    end
  end

  assign tdo = tdo_reg;
  assign tdo_oe = tdo_oe_reg;

  // Lane transmitter data
  assign tx_data = bsr_upd_next[bsac_pkg::CELL_AC_BASE-1:bsac_pkg::CELL_TX_BASE];

  bsac_tx_pulse u_tx (
    .tck(tck),
    .clr(tap_clr),
    .drive(drive_next),
    .train(ins_next == bsac_pkg::INS_TRAIN),
    .edge_mode(edge_next),
    .in_update((state_reg == bsac_pkg::TAP_UP_DR) || (state_reg == bsac_pkg::TAP_UP_IR)),
    .in_rti(state_reg == bsac_pkg::TAP_RTI),
    .data(tx_data),
    .tx_pair(serial_tx_pair)
  );
endmodule : bsac_top
`default_nettype wire

// [test/bsac_top_checker.sv]
// Timing checker for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module bsac_top_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic config_done,
  input wire logic scan_test_mode,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [bsac_pkg::N_IO-1:0] io_oe,
  input wire logic [2*bsac_pkg::N_LANE-1:0] serial_tx_pair
);
  localparam logic [63:0] NXT1 = 64'h2FEF_CC02_8785_5920;
  localparam logic [63:0] NXT0 = 64'h1BDD_BBA1_4664_4311;
  localparam logic [3:0] S_TLR = 4'h0;
  localparam logic [3:0] S_RTI = 4'h1;
  localparam logic [3:0] S_CDR = 4'h3;
  localparam logic [3:0] S_SDR = 4'h4;
  localparam logic [3:0] S_UDR = 4'h8;
  localparam logic [3:0] S_SIR = 4'hB;
  localparam logic [3:0] S_UIR = 4'hF;
  logic [3:0] st_reg;
  logic [3:0] st_next;
  logic [9:0] ir_reg;
  logic [9:0] ins_reg;
  logic pulse_on;
  logic train_on;

  assign st_next = tms ? NXT1[{st_reg, 2'h0} +: 4] : NXT0[{st_reg, 2'h0} +: 4];
  assign pulse_on = (ins_reg == bsac_pkg::OP_EXTEST_PULSE) && config_done;
  assign train_on = (ins_reg == bsac_pkg::OP_EXTEST_TRAIN) && config_done;

  always_ff @(posedge tck)
  begin
    if (!rst_n)
      st_reg <= S_TLR;
    else
      st_reg <= st_next;
  end
  always_ff @(posedge tck)
  begin
    if (st_reg == S_SIR)
      ir_reg <= {tdi, ir_reg[9:1]};
  end
  always_ff @(posedge tck)
  begin
    if (!rst_n || st_reg == S_TLR)
      ins_reg <= bsac_pkg::OP_DEVICE_IDENTIFICATION;
    else if (st_reg == S_UIR)
      ins_reg <= ir_reg;
  end

  sequence s_first_shift;
    st_reg == S_CDR ##1 st_reg == S_SDR;
  endsequence
  sequence s_upd_idle;
    st_reg == S_UDR ##1 st_reg == S_RTI;
  endsequence
  sequence s_idle_idle;
    st_reg == S_RTI ##1 st_reg == S_RTI;
  endsequence
  sequence s_idle_exit;
    st_reg == S_RTI ##1 st_reg != S_RTI;
  endsequence

  property p_tdo_oe;
    @(posedge tck) disable iff (!rst_n) tdo_oe == (st_reg == S_SDR || st_reg == S_SIR);
  endproperty
  a_tdo_oe: assert property (p_tdo_oe) else $error("tdo_oe not matching shift state");
  property p_legs;
    @(posedge tck) disable iff (!rst_n)
      ((serial_tx_pair ^ (serial_tx_pair >> 1)) & 16'h5555) == 16'h5555;
  endproperty
  a_legs: assert property (p_legs) else $error("tx legs not complementary");
  property p_invert;
    @(posedge tck) disable iff (!rst_n)
      s_upd_idle ##0 (pulse_on || train_on) |-> serial_tx_pair == ~$past(serial_tx_pair);
  endproperty
  a_invert: assert property (p_invert) else $error("tx not inverted in idle");
  property p_hold;
    @(posedge tck) disable iff (!rst_n) s_idle_idle ##0 pulse_on |-> $stable(serial_tx_pair);
  endproperty
  a_hold: assert property (p_hold) else $error("pulse tx moved in idle");
  property p_toggle;
    @(posedge tck) disable iff (!rst_n)
      s_idle_idle ##0 train_on |-> serial_tx_pair == ~$past(serial_tx_pair);
  endproperty
  a_toggle: assert property (p_toggle) else $error("train tx not toggling");
  property p_exit;
    @(posedge tck) disable iff (!rst_n)
      s_idle_exit ##0 pulse_on |-> serial_tx_pair == ~$past(serial_tx_pair);
  endproperty
  a_exit: assert property (p_exit) else $error("tx not restored after idle");
  property p_id_lsb;
    @(posedge tck) disable iff (!rst_n)
      s_first_shift ##0 (ins_reg == bsac_pkg::OP_DEVICE_IDENTIFICATION) |-> tdo == 1'h1;
  endproperty
  a_id_lsb: assert property (p_id_lsb) else $error("identification bit zero not one");
  property p_refused;
    @(posedge tck) disable iff (!rst_n)
      s_first_shift ##0 ((ins_reg == bsac_pkg::OP_EXTEST_PULSE ||
                          ins_reg == bsac_pkg::OP_EXTEST_TRAIN) && !config_done) |-> tdo == 1'h0;
  endproperty
  a_refused: assert property (p_refused) else $error("edge test taken before config");
  property p_mode_io;
    @(posedge clk) disable iff (!rst_n) (io_oe != '0) [*6] |-> scan_test_mode;
  endproperty
  a_mode_io: assert property (p_mode_io) else $error("pins driven without test mode");
endmodule : bsac_top_checker
`default_nettype wire

// [test/bsac_jtag_ctl.sv]
// Board test controller model for the four-wire test port
`timescale 1ns/1ps
`default_nettype none
module bsac_jtag_ctl (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial
  begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // One 6 ns period, clock idle low between frames
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #2;
    q = tdo;
    tck = 1'h1;
    #3;
    tck = 1'h0;
    #1;
  endtask : tick
  task automatic tlr();
    logic q;
    repeat (5) tick(1'h1, 1'h0, q);
    tick(1'h0, 1'h0, q);
  endtask : tlr
  // From Select-DR, LSB first, ends in Update
  task automatic scan(input logic ir, input int n, input logic [4095:0] din,
                      output logic [4095:0] dout);
    logic q;
    dout = '0;
    if (ir)
      tick(1'h1, 1'h0, q);
    tick(1'h0, 1'h0, q);
    tick(1'h0, 1'h0, q);
    for (int k = 0; k < n; k++)
    begin
      tick(k == n - 1, din[k], q);
      dout[k] = q;
    end
    tick(1'h1, 1'h0, q);
  endtask : scan
endmodule : bsac_jtag_ctl
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int N = bsac_pkg::BSR_LEN_SMALL;
  logic clk, rst_n, config_start_n, config_status_n, config_done, scan_test_mode;
  logic tck, tms, tdi, tdo, tdo_oe, q;
  logic [7:0] io_in, io_out, io_oe, serial_rx_pair, ref_clock_inputs;
  logic [15:0] serial_tx_pair;
  logic [4095:0] din, dout;
  int failures, n_compared;

  always #2 clk = ~clk;
  bsac_top #(.DEV_SIZE(2'h0)) dut_u (.clk(clk), .rst_n(rst_n), .config_start_n(config_start_n),
    .config_status_n(config_status_n), .config_done(config_done),
    .scan_test_mode(scan_test_mode), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .serial_tx_pair(serial_tx_pair), .serial_rx_pair(serial_rx_pair),
    .ref_clock_inputs(ref_clock_inputs));
  bsac_jtag_ctl ctl_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  function automatic logic [31:0] pr(input logic [7:0] d);
    pr = '0;
    for (int i = 0; i < 8; i++)
      pr[2*i +: 2] = {~d[i], d[i]};
  endfunction : pr
  task automatic settle();
    repeat (12) @(negedge clk);
  endtask : settle
  task automatic load_ir(input logic [9:0] op);
    ctl_u.scan(1'h1, 10, 4096'(op), dout);
    ctl_u.tick(1'h1, 1'h0, q);
  endtask : load_ir
  task automatic conclude();
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  initial
  begin
    clk = 1'h0;
    rst_n = 1'h0;
    config_start_n = 1'h1;
    config_status_n = 1'h1;
    config_done = 1'h0;
    io_in = 8'hFF;
    serial_rx_pair = 8'h00;
    ref_clock_inputs = 8'h00;
    failures = 0;
    n_compared = 0;
    din = '0;
    ctl_u.tlr();
    @(negedge clk);
    rst_n = 1'h1;
    settle();
    ctl_u.tlr();
    ctl_u.tick(1'h1, 1'h0, q);
    load_ir(bsac_pkg::OP_DEVICE_IDENTIFICATION);
    ctl_u.scan(1'h0, 32, din, dout);
    chk("device_identification", {bsac_pkg::ID_VERSION, bsac_pkg::ID_PART_SMALL, bsac_pkg::ID_MFR, 1'h1},
        dout[31:0]);
    ctl_u.tick(1'h1, 1'h0, q);
    load_ir(bsac_pkg::OP_EXTEST_PULSE);
    din = 4096'(8'hB5);
    ctl_u.scan(1'h0, 8, din, dout);
    chk("bypass", 32'h6A, dout[31:0]);
    ctl_u.tick(1'h1, 1'h0, q);
    settle();
    chk("mode_off", 32'h0, 32'(scan_test_mode));
    config_status_n = 1'h0;
    settle();
    ctl_u.tlr();
    ctl_u.tick(1'h1, 1'h0, q);
    ctl_u.scan(1'h0, 32, din, dout);
    chk("id_invalid", bsac_pkg::ID_INVALID, dout[31:0]);
    ctl_u.tick(1'h1, 1'h0, q);
    @(negedge clk);
    config_status_n = 1'h1;
    config_done = 1'h1;
    settle();
    load_ir(bsac_pkg::OP_SAMPLE);
    din = '0;
    for (int k = N; k < 2*N+8; k++)
      din[k] = 1'h1;
    ctl_u.scan(1'h0, 2*N+8, din, dout);
    chk("chain", 32'h1, 32'((dout[2*N-1:N] == '0) && (dout[2*N+7 -: 8] == 8'hFF)));
    ctl_u.tick(1'h1, 1'h0, q);
    load_ir(bsac_pkg::OP_EXTEST_PULSE);
    din = '0;
    for (int k = 0; k < 8; k++)
      din[3*k+1 +: 2] = {1'h1, k[0]};
    din[31:24] = 8'hA5;
    ctl_u.scan(1'h0, N, din, dout);
    chk("tx_update", pr(8'hA5), 32'(serial_tx_pair));
    chk("io", 32'hFFAA, {16'h0, io_oe, io_out});
    ctl_u.tick(1'h0, 1'h0, q);
    chk("tx_idle", pr(8'h5A), 32'(serial_tx_pair));
    @(negedge clk);
    serial_rx_pair = 8'h0F;
    ref_clock_inputs = 8'h03;
    for (int i = 0; i < 3; i++)
    begin
      ctl_u.tick(1'h0, 1'h0, q);
      chk("tx_hold", pr(8'h5A), 32'(serial_tx_pair));
    end
    ctl_u.tick(1'h1, 1'h0, q);
    chk("tx_exit", pr(8'hA5), 32'(serial_tx_pair));
    settle();
    chk("mode_on", 32'h1, 32'(scan_test_mode));
    ctl_u.scan(1'h0, N, din, dout);
    chk("rx_edge", 32'h030F, 32'(dout[47:32]));
    ctl_u.tick(1'h1, 1'h0, q);
    load_ir(bsac_pkg::OP_EXTEST_TRAIN);
    ctl_u.scan(1'h0, N, din, dout);
    for (int i = 0; i < 4; i++)
    begin
      ctl_u.tick(1'h0, 1'h0, q);
      chk("tx_train", pr(i[0] ? 8'hA5 : 8'h5A), 32'(serial_tx_pair));
    end
    conclude();
  end
endmodule : testbench
bind bsac_top bsac_top_checker chk_u (.clk(clk), .rst_n(rst_n), .config_done(config_done),
  .scan_test_mode(scan_test_mode), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .tdo_oe(tdo_oe), .io_oe(io_oe), .serial_tx_pair(serial_tx_pair));
`default_nettype wire
